// ---- hdl/bdmd_map.svh ----
`ifndef BDMD_MAP_SVH
`define BDMD_MAP_SVH

// Scheme encodings on the two-bit setting
`define BDMD_SCHEME_SIX       2'h0
`define BDMD_SCHEME_SIX_LIM   2'h1
`define BDMD_SCHEME_THREE     2'h2
`define BDMD_SCHEME_THREE_LIM 2'h3

// Strap levels as seen by the strap decoder
`define BDMD_STRAP_GND        2'h0
`define BDMD_STRAP_FLOAT      2'h1
`define BDMD_STRAP_RES_RAIL   2'h2
`define BDMD_STRAP_RAIL       2'h3

// Timing
`define BDMD_CLK_HZ           10000000
`define BDMD_BLANK_NS         5000
`define BDMD_CLK_NS           100
`define BDMD_READY_US         1000

`endif

// ---- hdl/bdmd_pkg.sv ----
package bdmd_pkg;
  typedef enum logic [1:0] {
    BDMD_PH_HIZ,
    BDMD_PH_LOW,
    BDMD_PH_HIGH
  } bdmd_phase_t;

  typedef enum logic [1:0] {
    BDMD_ST_RESET,
    BDMD_ST_SAMPLE,
    BDMD_ST_RUN,
    BDMD_ST_TEST
  } bdmd_state_t;
endpackage

// ---- hdl/bdmd_phase_decode.sv ----
`timescale 1ns/1ps
`include "bdmd_map.svh"

// One phase: decodes synchronised gate inputs into a drive state
module bdmd_phase_decode (
  input  wire logic                 high_side_in,  // Synchronised high-side input
  input  wire logic                 low_side_in,   // Synchronised low-side input
  input  wire logic                 three_input,   // Scheme is three-input
  input  wire logic                 enable,        // Drive allowed
  output bdmd_pkg::bdmd_phase_t     phase_state    // Decoded state
);
  wire logic six_hiz;
  wire logic three_hiz;

  assign six_hiz   = (high_side_in == low_side_in);
  assign three_hiz = !low_side_in;

  assign phase_state = !enable ? bdmd_pkg::BDMD_PH_HIZ :
                       three_input ? (three_hiz ? bdmd_pkg::BDMD_PH_HIZ :
                                      (high_side_in ? bdmd_pkg::BDMD_PH_HIGH : bdmd_pkg::BDMD_PH_LOW)) :
                       (six_hiz ? bdmd_pkg::BDMD_PH_HIZ :
                        (high_side_in ? bdmd_pkg::BDMD_PH_HIGH : bdmd_pkg::BDMD_PH_LOW));
endmodule // bdmd_phase_decode

// ---- hdl/bdmd_top.sv ----
// How it works
// - Four schemes by two-bit setting: six, six limited, three, three limited.
// - Strap variant maps ground, float, resistor-rail, rail onto the same four schemes.
// - Limited schemes: shared pin is current threshold, sense outputs unavailable.
// - Unlimited schemes: shared pin is sense reference, all three sense outputs available in run state only (not start-up or test mode).
// - Six-input: equal inputs give Hi-Z, high-side alone high, low-side alone low.
// - Fault pin not pulled high at power-up puts device in test mode.
// - Any fault event drives fault pin; cause held in readable status.
// - Three-input: low-side zero gives Hi-Z, else phase follows high-side input.
// - Limit comparator result ignored five microseconds after each output transition.
`timescale 1ns/1ps
`include "bdmd_map.svh"

module bdmd_top #(
  parameter int PHASES = 3  // Number of half-bridges
) (
  input  wire logic                          ref_clk,             // 10 MHz clock
  input  wire logic                          reset_n,             // Async reset, active low
  input  wire logic [PHASES-1:0]             high_side_in,        // High-side gate inputs
  input  wire logic [PHASES-1:0]             low_side_in,         // Low-side gate inputs
  input  wire logic                          strap_variant,       // 1: scheme from strap
  input  wire logic [1:0]                    scheme_setting,      // Serial-variant scheme bits
  input  wire logic [1:0]                    scheme_strap,        // Strap level code
  input  wire logic                          limit_trip,          // Current limit comparator
  input  wire logic [3:0]                    fault_events,        // Detected fault causes
  input  wire logic                          fault_clear,         // Clear latched causes
  input  wire logic                          fault_indicator_n_i, // Fault pin level sensed
  output logic                               fault_indicator_n_o, // Fault pin driven value
  output logic                               fault_indicator_n_oe,// Fault pin pull-down enable
  output logic [2*PHASES-1:0]                phase_out,           // Per phase 2-bit state: 0 Hi-Z, 1 low, 2 high
  output logic [1:0]                         scheme_q,            // Active scheme
  output logic                               ref_is_limit,        // Shared pin is threshold
  output logic                               sense_amp_out_en,    // Sense outputs available
  output logic                               limit_active,        // Phases clamped by limit
  output logic [3:0]                         fault_cause_q,       // Latched fault causes
  output logic                               test_mode            // Internal test mode
);
  localparam int BLANK_CYC = (`BDMD_BLANK_NS + `BDMD_CLK_NS - 1) / `BDMD_CLK_NS;
  localparam int BLANK_W   = $clog2(BLANK_CYC + 1);

  // Refuse a bridge with no phases before anything is built
  if (PHASES < 1) begin : g_bad_phases
    $error("PHASES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [PHASES-1:0] hs_meta_q, hs_sync_q, ls_meta_q, ls_sync_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_meta_q <= '0;
      hs_sync_q <= '0;
      ls_meta_q <= '0;
      ls_sync_q <= '0;
    end else begin
      hs_meta_q <= high_side_in;
      hs_sync_q <= hs_meta_q;
      ls_meta_q <= low_side_in;
      ls_sync_q <= ls_meta_q;
    end
  end

  // Gate edges are seen between stage two and a history stage; the first stage
  // may be metastable, so nothing but stage two reads it
  logic [PHASES-1:0]      hs_prev_q, ls_prev_q;
  wire logic [PHASES-1:0] hs_edge;
  wire logic [PHASES-1:0] ls_edge;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_prev_q <= '0;
      ls_prev_q <= '0;
    end else begin
      hs_prev_q <= hs_sync_q;
      ls_prev_q <= ls_sync_q;
    end
  end

  assign hs_edge = hs_sync_q ^ hs_prev_q;
  assign ls_edge = ls_sync_q ^ ls_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Scheme selection and start-up
  bdmd_pkg::bdmd_state_t state_q, state_d;
  logic [1:0]            scheme_d;
  wire logic [1:0]       strap_scheme;
  wire logic [1:0]       sel_scheme;
  wire logic             is_limit;
  wire logic             three_in;
  wire logic             drive_en;

  // Strap codes map one to one onto the scheme encodings
  assign strap_scheme = (scheme_strap == `BDMD_STRAP_GND)      ? `BDMD_SCHEME_SIX :
                        (scheme_strap == `BDMD_STRAP_FLOAT)    ? `BDMD_SCHEME_SIX_LIM :
                        (scheme_strap == `BDMD_STRAP_RES_RAIL) ? `BDMD_SCHEME_THREE :
                                                                 `BDMD_SCHEME_THREE_LIM;
  assign sel_scheme   = strap_variant ? strap_scheme : scheme_setting;

  always_comb begin
    state_d  = state_q;
    scheme_d = scheme_q;
    case (state_q)
      bdmd_pkg::BDMD_ST_RESET:  state_d = bdmd_pkg::BDMD_ST_SAMPLE;
      bdmd_pkg::BDMD_ST_SAMPLE: begin
        scheme_d = sel_scheme;
        // Pin not released high by the pull-up means test mode
        state_d  = fault_indicator_n_i ? bdmd_pkg::BDMD_ST_RUN
                                       : bdmd_pkg::BDMD_ST_TEST;
      end
      // Live changes follow the setting; the controller parks inputs first
      bdmd_pkg::BDMD_ST_RUN:    scheme_d = sel_scheme;
      bdmd_pkg::BDMD_ST_TEST:   state_d  = bdmd_pkg::BDMD_ST_TEST;
      default:                  state_d  = bdmd_pkg::BDMD_ST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= bdmd_pkg::BDMD_ST_RESET;
      scheme_q <= `BDMD_SCHEME_SIX;
    end else begin
      state_q  <= state_d;
      scheme_q <= scheme_d;
    end
  end

  assign is_limit         = (scheme_q == `BDMD_SCHEME_SIX_LIM) || (scheme_q == `BDMD_SCHEME_THREE_LIM);
  assign three_in         = (scheme_q == `BDMD_SCHEME_THREE) || (scheme_q == `BDMD_SCHEME_THREE_LIM);
  assign ref_is_limit     = is_limit;
  assign sense_amp_out_en = drive_en && !is_limit;
  assign test_mode        = (state_q == bdmd_pkg::BDMD_ST_TEST);
  // Clamp and start-up both reach the pins as Hi-Z through the decoders
  assign drive_en         = (state_q == bdmd_pkg::BDMD_ST_RUN) && !limit_active;

  ////////////////////////////////////////////////////////////////////////////
  // Phase decode
  bdmd_pkg::bdmd_phase_t phase_comb [PHASES];
  bdmd_pkg::bdmd_phase_t phase_q    [PHASES];
  logic [PHASES-1:0]     phase_chg;

  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : g_phase
      bdmd_phase_decode u_dec (
        .high_side_in (hs_sync_q[g]),
        .low_side_in  (ls_sync_q[g]),
        .three_input  (three_in),
        .enable       (drive_en),
        .phase_state  (phase_comb[g])
      );
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          phase_q[g] <= bdmd_pkg::BDMD_PH_HIZ;
        end else begin
          phase_q[g] <= phase_comb[g];
        end
      end
      assign phase_chg[g]         = (phase_comb[g] != phase_q[g]);
      assign phase_out[2*g +: 2]  = phase_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Cycle-by-cycle limit with blanking
  // Clamp lasts until the controller's own next transition, i.e. one PWM cycle
  logic [BLANK_W-1:0] blank_q;
  logic               limit_q;
  wire logic          blanked;
  wire logic          in_chg;
  wire logic          limit_hit;
  wire logic          limit_release;

  // Switching noise on the sense path would otherwise trip the clamp at once
  assign blanked       = (blank_q != '0);
  assign in_chg        = (|hs_edge) || (|ls_edge);
  assign limit_hit     = is_limit && limit_trip && !blanked;
  assign limit_release = !is_limit || in_chg;
  assign limit_active  = limit_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      blank_q <= '0;
    end else if (|phase_chg) begin
      blank_q <= BLANK_W'(BLANK_CYC);
    end else if (blanked) begin
      blank_q <= blank_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clamp register
  // Release first: a gate edge ends the clamp even while the trip persists
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      limit_q <= 1'b0;
    end else if (limit_release) begin
      limit_q <= 1'b0;
    end else if (limit_hit) begin
      limit_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault indication
  wire logic [3:0] fault_next;

  // Set wins over clear, so an event in the clearing cycle is never lost
  assign fault_next = (fault_clear ? 4'h0 : fault_cause_q) | fault_events;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_cause_q <= '0;
    end else begin
      fault_cause_q <= fault_next;
    end
  end

  // Open drain: the board pull-up gives the released level
  assign fault_indicator_n_o  = 1'b0;
  assign fault_indicator_n_oe = |fault_cause_q;
endmodule // bdmd_top

// ---- verif/bdmd_top_props.sv ----
`timescale 1ns/1ps
module bdmd_top_props #(parameter int PHASES = 3) (
  input wire logic                ref_clk,              // Block clock
  input wire logic                reset_n,              // Async reset, active low
  input wire logic [PHASES-1:0]   high_side_in,         // High-side gate inputs
  input wire logic [PHASES-1:0]   low_side_in,          // Low-side gate inputs
  input wire logic [3:0]          fault_events,         // Fault causes
  input wire logic                fault_indicator_n_i,  // Sensed fault pin
  input wire logic                fault_indicator_n_oe, // Fault pin pull-down
  input wire logic [2*PHASES-1:0] phase_out,            // Phase states
  input wire logic [1:0]          scheme_q,             // Active scheme
  input wire logic                ref_is_limit,         // Shared pin role
  input wire logic                sense_amp_out_en,     // Sense outputs on
  input wire logic                limit_active,         // Clamp on
  input wire logic [3:0]          fault_cause_q,        // Latched causes
  input wire logic                test_mode             // Test mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Five samples cover two sync stages plus the output register
  sequence s_hold(logic [1:0] s, logic h, logic l);
    (scheme_q == s && !test_mode && high_side_in[0] == h && low_side_in[0] == l) [*5];
  endsequence
  sequence s_rel;
    $rose(reset_n) ##1 !fault_indicator_n_i;
  endsequence
  hiz_release_a: assert property ($rose(reset_n) |-> phase_out == '0 ##1 phase_out == '0)
    else $error("phase left Hi-Z before scheme sampled");
  six_high_a: assert property (s_hold(2'h0, 1'b1, 1'b0) |-> phase_out[1:0] == 2'h2)
    else $error("six-input high decode wrong");
  six_low_a: assert property (s_hold(2'h0, 1'b0, 1'b1) |-> phase_out[1:0] == 2'h1)
    else $error("six-input low decode wrong");
  six_both_a: assert property (s_hold(2'h0, 1'b1, 1'b1) |-> phase_out[1:0] == 2'h0)
    else $error("six-input both high not Hi-Z");
  three_off_a: assert property (s_hold(2'h2, 1'b1, 1'b0) |-> phase_out[1:0] == 2'h0)
    else $error("three-input off not Hi-Z");
  three_high_a: assert property (s_hold(2'h2, 1'b1, 1'b1) |-> phase_out[1:0] == 2'h2)
    else $error("three-input high decode wrong");
  ref_pin_a: assert property (ref_is_limit == scheme_q[0])
    else $error("shared pin role wrong");
  sense_off_a: assert property (sense_amp_out_en |-> !scheme_q[0])
    else $error("sense outputs on in limit scheme");
  limit_scheme_a: assert property ($rose(limit_active) |-> scheme_q[0])
    else $error("clamp in unlimited scheme");
  test_hiz_a: assert property (test_mode |-> phase_out == '0)
    else $error("phase driven in test mode");
  test_entry_a: assert property (s_rel |=> test_mode)
    else $error("low fault pin did not enter test mode");
  fault_latch_a: assert property (fault_events[0] |=> fault_cause_q[0] && fault_indicator_n_oe)
    else $error("fault event not latched");
endmodule // bdmd_top_props
bind bdmd_top bdmd_top_props #(.PHASES(PHASES)) u_props (
  .ref_clk              (ref_clk),
  .reset_n              (reset_n),
  .high_side_in         (high_side_in),
  .low_side_in          (low_side_in),
  .fault_events         (fault_events),
  .fault_indicator_n_i  (fault_indicator_n_i),
  .fault_indicator_n_oe (fault_indicator_n_oe),
  .phase_out            (phase_out),
  .scheme_q             (scheme_q),
  .ref_is_limit         (ref_is_limit),
  .sense_amp_out_en     (sense_amp_out_en),
  .limit_active         (limit_active),
  .fault_cause_q        (fault_cause_q),
  .test_mode            (test_mode)
);

// ---- verif/bdmd_mcu_model.sv ----
`timescale 1ns/1ps
module bdmd_mcu_model (
  input wire logic       park,         // Hold all gates low
  input wire logic [2:0] cmd_hs,       // Wanted high-side levels
  input wire logic [2:0] cmd_ls,       // Wanted low-side levels
  input wire logic       pull_ok,      // Board pull-up fitted
  input wire logic       pin_oe,       // Block pulls fault pin low
  output logic [2:0]     high_side_in, // High-side gate pins
  output logic [2:0]     low_side_in,  // Low-side gate pins
  output logic           pin_level     // Fault pin level
);
  // Gates parked low around any scheme change
  assign high_side_in = park ? 3'h0 : cmd_hs;
  assign low_side_in  = park ? 3'h0 : cmd_ls;
  // Open drain; a missing pull-up reads low
  assign pin_level = pin_oe ? 1'b0 : pull_ok;
endmodule // bdmd_mcu_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, reset_n, strap_variant, limit_trip, fault_clear, park, pull_ok;
  logic fault_indicator_n_i, fault_indicator_n_o, fault_indicator_n_oe;
  logic ref_is_limit, sense_amp_out_en, limit_active, test_mode;
  logic [1:0] scheme_setting, scheme_strap, scheme_q;
  logic [2:0] cmd_hs, cmd_ls, high_side_in, low_side_in;
  logic [3:0] fault_events, fault_cause_q;
  logic [5:0] phase_out;
  int         errors, tests_run;
  bdmd_top uut (
    .ref_clk              (ref_clk),
    .reset_n              (reset_n),
    .high_side_in         (high_side_in),
    .low_side_in          (low_side_in),
    .strap_variant        (strap_variant),
    .scheme_setting       (scheme_setting),
    .scheme_strap         (scheme_strap),
    .limit_trip           (limit_trip),
    .fault_events         (fault_events),
    .fault_clear          (fault_clear),
    .fault_indicator_n_i  (fault_indicator_n_i),
    .fault_indicator_n_o  (fault_indicator_n_o),
    .fault_indicator_n_oe (fault_indicator_n_oe),
    .phase_out            (phase_out),
    .scheme_q             (scheme_q),
    .ref_is_limit         (ref_is_limit),
    .sense_amp_out_en     (sense_amp_out_en),
    .limit_active         (limit_active),
    .fault_cause_q        (fault_cause_q),
    .test_mode            (test_mode)
  );
  bdmd_mcu_model u_mcu (.park(park), .cmd_hs(cmd_hs), .cmd_ls(cmd_ls), .pull_ok(pull_ok),
    .pin_oe(fault_indicator_n_oe), .high_side_in(high_side_in), .low_side_in(low_side_in),
    .pin_level(fault_indicator_n_i));
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task do_reset(input logic pull);
    pull_ok = pull;
    reset_n = 1'b0;
    cyc(4);
    reset_n = 1'b1;
    cyc(3);
  endtask
  task set_scheme(input logic [1:0] s);
    park = 1'b1;
    cyc(4);
    scheme_setting = s;
    cyc(2);
    park = 1'b0;
  endtask
  // Output settles after three edges; five keep it up for the decode properties
  task drive(input logic [2:0] h, input logic [2:0] l);
    cmd_hs = h;
    cmd_ls = l;
    cyc(5);
  endtask
  task t_decode(input logic three);
    logic [1:0] e;
    set_scheme(three ? 2'h2 : 2'h0);
    for (int i = 0; i < 4; i++) begin
      drive({3{i[0]}}, {3{i[1]}});
      if (three) e = !i[1] ? 2'h0 : (i[0] ? 2'h2 : 2'h1);
      else e = (i[0] == i[1]) ? 2'h0 : (i[0] ? 2'h2 : 2'h1);
      check(phase_out, {3{e}});
    end
    cmd_ls = 3'h1;
    cyc(2);
    check(phase_out, three ? 6'h2a : 6'h00);
    cyc(1);
    check(phase_out, three ? 6'h02 : 6'h28);
  endtask
  task t_limit;
    for (int s = 0; s < 4; s++) begin
      set_scheme(s[1:0]);
      check(ref_is_limit, s[0]);
      check(sense_amp_out_en, !s[0]);
      cyc(1);
    end
    drive(3'h7, 3'h7);
    limit_trip = 1'b1;
    cyc(1);
    limit_trip = 1'b0;
    cyc(1);
    check(limit_active, 1'b0);
    cyc(60);
    limit_trip = 1'b1;
    cyc(1);
    limit_trip = 1'b0;
    cyc(2);
    check(limit_active, 1'b1);
    check(phase_out, 6'h00);
    drive(3'h7, 3'h6);
    check(limit_active, 1'b0);
    check(phase_out, 6'h28);
    set_scheme(2'h0);
    cyc(60);
    limit_trip = 1'b1;
    cyc(2);
    limit_trip = 1'b0;
    check(limit_active, 1'b0);
  endtask
  task t_strap;
    park = 1'b1;
    strap_variant = 1'b1;
    for (int s = 0; s < 4; s++) begin
      scheme_strap = s[1:0];
      cyc(2);
      check(scheme_q, s[1:0]);
    end
    strap_variant = 1'b0;
    cyc(2);
  endtask
  task t_fault;
    for (int i = 0; i < 4; i++) begin
      fault_events = 4'h1 << i;
      cyc(1);
      fault_events = 4'h0;
      cyc(2);
      check(fault_cause_q, 4'h1 << i);
      check(fault_indicator_n_i, 1'b0);
      check(fault_indicator_n_oe, 1'b1);
      check(fault_indicator_n_o, 1'b0);
      fault_clear = 1'b1;
      cyc(1);
      fault_clear = 1'b0;
      check(fault_cause_q, 4'h0);
      check(fault_indicator_n_i, 1'b1);
    end
  endtask
  task t_test;
    do_reset(1'b0);
    check(test_mode, 1'b1);
    park = 1'b0;
    drive(3'h1, 3'h0);
    check(phase_out, 6'h00);
    do_reset(1'b1);
    check(test_mode, 1'b0);
    check(phase_out, 6'h02);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // About 10300 cycles with the start-up wait; 20000 means a hang
  initial begin
    #2000000;
    errors++;
    give_verdict;
  end
  initial begin
    {strap_variant, limit_trip, fault_clear, scheme_setting, scheme_strap} = '0;
    {cmd_hs, cmd_ls, fault_events, errors, tests_run} = '0;
    park = 1'b1;
    do_reset(1'b1);
    // Configuration left alone for one millisecond after power-up
    cyc(10000);
    t_decode(1'b0);
    t_decode(1'b1);
    t_limit;
    t_strap;
    t_fault;
    t_test;
    give_verdict;
  end
endmodule // tb_top
